/* File: dv/rsar_core_bench.sv */
// Purpose: self-checking bench for rsar_core
// Assumes: short timer parameters, prompt and slow memory
// Notes: runs the current table, then the voltage table
`timescale 1ns/1ps
module rsar_core_bench;
  localparam int CT_T [23] = '{500, 600, 750, 800, 900, 1000, 1100, 1200, 1500, 1600, 2000,
    2200, 2400, 2500, 3000, 3500, 4000, 4500, 5000, 6000, 7500, 8000, 9000};
  localparam int PT_T [32] = '{100, 110, 115, 120, 137, 140, 150, 173, 175, 180, 200, 231,
    240, 250, 251, 300, 346, 350, 375, 400, 435, 450, 500, 577, 600, 625, 635, 664, 693, 700,
    800, 808};
  logic clk_sys_i = 0, reset_i = 1, power_good_i = 1, wdt_kick_i = 1, button_i = 0;
  logic decimal_point_jumper_i = 0, voltage_transformer_i = 0;
  logic [1:0] toggle_i = 0;
  logic [14:0] rms_i = 0;
  logic [15:0] meas_data_i = 0;
  logic [3:0] dly_i = 0;
  wire wdt_recover_o, resumed_o, demand_reset_o, nvm_req_o, nvm_we_o, nvm_done_i, disp_point_o;
  wire [1:0] nvm_addr_o, disp_mode_o;
  wire [15:0] meas_data_o, nvm_wdata_o, nvm_rdata_i;
  wire [13:0] disp_ratio_o;
  wire [14:0] disp_value_o;
  int fails = 0, comparisons = 0, act = 0, sel, n;
  rsar_core #(.WDT_CYC(25'd20), .CHECK_CYC(25'd8), .CONFIRM_CYC(25'd8), .DEBOUNCE_CYC(25'd3))
    DUT (.clk_sys_i, .reset_i, .power_good_i, .wdt_kick_i, .wdt_recover_o, .toggle_i,
    .button_i, .decimal_point_jumper_i, .voltage_transformer_i, .rms_i, .meas_data_i,
    .meas_data_o, .resumed_o, .demand_reset_o, .nvm_req_o, .nvm_we_o, .nvm_addr_o,
    .nvm_wdata_o, .nvm_rdata_i, .nvm_done_i, .disp_mode_o, .disp_ratio_o, .disp_value_o,
    .disp_point_o);
  rsar_nvm_model pm (.clk_sys_i, .reset_i, .req_i(nvm_req_o), .we_i(nvm_we_o),
    .addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o), .dly_i, .rdata_o(nvm_rdata_i),
    .done_o(nvm_done_i));
  // ==========
  initial
  begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  function int rt(input int i);
    return voltage_transformer_i ? PT_T[i] : CT_T[i];
  endfunction
  task chk(input logic [15:0] got, input int exp);
    comparisons++;
    if (got !== 16'(exp))
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, 16'(exp));
    end
  endtask
  task wrap_up;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // 0 resume pulse, 1 watchdog pulse, 2 normal display
  task wait_on(input int w);
    int c;
    c = 0;
    while (!(w == 0 ? resumed_o === 1'b1 : w == 1 ? wdt_recover_o === 1'b1 :
      disp_mode_o === 2'h0) && c < 200)
    begin
      tick(1);
      c++;
    end
    if (c >= 200)
    begin
      fails++;
      $display("wrong value at %0t: wait timed out", $time);
      wrap_up;
    end
  endtask
  // release must outlast the debounce window, or the next press is lost
  task press(input int dr);
    button_i <= 1'b1;
    tick(4);
    chk(16'(demand_reset_o), dr);
    button_i <= 1'b0;
    tick(4);
  endtask
  // ==========
  initial
  begin
    for (int p = 0; p < 2; p++)
    begin
      voltage_transformer_i <= p[0];
      decimal_point_jumper_i <= p[0];
      n = p ? 32 : 23;
      reset_i <= 1'b1;
      tick(4);
      reset_i <= 1'b0;
      wait_on(0);
      chk(16'(disp_point_o), p);
      chk(16'(disp_ratio_o), rt(act));
      toggle_i <= 2'h1;
      tick(2);
      chk(16'(disp_mode_o), 1);
      chk(16'(disp_ratio_o), rt(act));
      for (int k = 1; k <= n + 1; k++)
      begin
        press(0);
        chk(16'(disp_ratio_o), rt((act + k) % n));
      end
      sel = (act + 1) % n;
      toggle_i <= 2'h0;
      tick(2);
      chk(16'(disp_mode_o), 2);
      wait_on(2);
      // the display follows the committed index one cycle later
      tick(1);
      chk(16'(disp_ratio_o), rt(sel));
      rms_i <= 15'd5000;
      tick(3);
      chk(16'(disp_value_o), rt(sel) / 2);
      rms_i <= 15'd10000;
      tick(3);
      chk(16'(disp_value_o), rt(sel));
      rms_i <= 15'd0;
      tick(3);
      chk(16'(disp_value_o), 0);
      press(1);
      chk(16'(disp_mode_o), 3);
      chk(16'(disp_ratio_o), rt(sel));
      tick(12);
      meas_data_i <= 16'hc35a ^ 16'(p);
      dly_i <= 4'h0;
      power_good_i <= 1'b0;
      tick(1);
      meas_data_i <= 16'h0000;
      tick(20);
      chk(pm.mem_q[1], 16'hc35a ^ p);
      chk(pm.mem_q[0] & 16'h001f, sel);
      dly_i <= 4'h3;
      power_good_i <= 1'b1;
      wait_on(0);
      chk(meas_data_o, 16'hc35a ^ p);
      chk(16'(disp_ratio_o), rt(sel));
      act = sel;
      $display("test table %0d done", p);
    end
    wdt_kick_i <= 1'b0;
    tick(19);
    chk(16'(wdt_recover_o), 0);
    tick(1);
    wdt_kick_i <= 1'b1;
    chk(16'(wdt_recover_o), 1);
    $display("test watchdog done");
    wrap_up;
  end
endmodule

/* File: dv/rsar_nvm_model.sv */
// Purpose: behavioural nonvolatile word memory on the far side
// Assumes: one request at a time, done one cycle wide
// Notes: dly_i sets the answer latency, 0 is prompt
`timescale 1ns/1ps
module rsar_nvm_model
(
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // memory bus
  input wire req_i,
  input wire we_i,
  input wire [1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire [3:0] dly_i,
  output wire [15:0] rdata_o,
  output reg done_o
);
  reg [15:0] mem_q [0:3];
  reg [3:0] wait_q;
  // ==========
  // contents survive reset, as real storage would
  initial
  begin
    for (int i = 0; i < 4; i++)
      mem_q[i] = 16'h0000;
  end
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      done_o <= 1'b0;
      wait_q <= 4'h0;
    end
    else
    begin
      done_o <= 1'b0;
      if (req_i && !done_o)
      begin
        if (wait_q >= dly_i)
        begin
          done_o <= 1'b1;
          wait_q <= 4'h0;
          if (we_i)
            mem_q[addr_i] <= wdata_i;
        end
        else
          wait_q <= wait_q + 4'h1;
      end
    end
  end
  // junk outside done, so a late sample cannot pass by luck
  assign rdata_o = done_o ? mem_q[addr_i] : ~mem_q[addr_i];
endmodule

/* File: dv/rsar_properties.sv */
// Purpose: concurrent checks on the rsar_core ports
// Assumes: one clock, reset_i synchronous active high
// Notes: bound into every rsar_core instance
`timescale 1ns/1ps
module rsar_props
#(
  parameter [24:0] WDT_CYC = 25'd20,
  parameter [24:0] CHECK_CYC = 25'd8
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // supply, controller, panel
  input wire power_good_i,
  input wire wdt_kick_i,
  input wire wdt_recover_o,
  input wire [1:0] toggle_i,
  input wire button_i,
  input wire decimal_point_jumper_i,
  input wire resumed_o,
  input wire demand_reset_o,
  // memory bus and display
  input wire nvm_req_o,
  input wire nvm_we_o,
  input wire [1:0] nvm_addr_o,
  input wire [15:0] nvm_wdata_o,
  input wire nvm_done_i,
  input wire [1:0] disp_mode_o,
  input wire disp_point_o
);
  localparam int CK = CHECK_CYC + 3;
  reg [24:0] idle_q;
  // ==========
  // cycles since the last kick or recovery
  always @(posedge clk_sys_i)
    idle_q <= (reset_i || wdt_kick_i || wdt_recover_o) ? 25'h0 : idle_q + 25'h1;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // a read is dropped on purpose when the supply fails again
  sequence s_word_wait;
    nvm_req_o && !nvm_done_i && (nvm_we_o || power_good_i);
  endsequence
  sequence s_idx_saved;
    nvm_req_o && nvm_done_i && nvm_we_o && nvm_addr_o == 2'h0;
  endsequence
  sequence s_gap_then_data;
    !nvm_req_o ##1 nvm_req_o && nvm_we_o && nvm_addr_o == 2'h1;
  endsequence
  // ==========
  a_req_holds: assert property (s_word_wait |=> nvm_req_o && $stable(nvm_addr_o) &&
    $stable(nvm_we_o) && $stable(nvm_wdata_o)) else $error("memory request changed early");
  a_req_drops: assert property (nvm_req_o && nvm_done_i |=> !nvm_req_o)
    else $error("memory request held after done");
  a_save_order: assert property (s_idx_saved |=> s_gap_then_data)
    else $error("data word not written after index");
  a_save_start: assert property ($rose(nvm_req_o) && nvm_we_o && nvm_addr_o == 2'h0
    |-> !$past(power_good_i)) else $error("save without power fail");
  a_resume_pulse: assert property (resumed_o |->
    $past(nvm_done_i && nvm_req_o && !nvm_we_o && nvm_addr_o == 2'h1))
    else $error("resume without data read");
  a_wdt_count: assert property (wdt_recover_o |-> idle_q + 25'd2 >= WDT_CYC)
    else $error("watchdog fired early");
  a_wdt_bound: assert property (idle_q <= WDT_CYC + 25'd1)
    else $error("watchdog did not fire");
  a_point_copy: assert property (!$past(reset_i) |->
    disp_point_o == $past(decimal_point_jumper_i)) else $error("decimal point not from jumper");
  a_ratio_mode: assert property ($rose(disp_mode_o == 2'h1) |-> $past(toggle_i) == 2'h1)
    else $error("ratio display without toggle");
  a_check_ends: assert property ($rose(disp_mode_o == 2'h2) |-> ##[1:CK] disp_mode_o == 2'h0)
    else $error("digit check did not end");
  a_press_stable: assert property (demand_reset_o |-> $past(button_i, 3) ##1 !demand_reset_o)
    else $error("press pulse without held button");
endmodule

bind rsar_core rsar_props #(.WDT_CYC(WDT_CYC), .CHECK_CYC(CHECK_CYC)) u_props (.clk_sys_i,
  .reset_i, .power_good_i, .wdt_kick_i, .wdt_recover_o, .toggle_i, .button_i,
  .decimal_point_jumper_i, .resumed_o, .demand_reset_o, .nvm_req_o, .nvm_we_o, .nvm_addr_o,
  .nvm_wdata_o, .nvm_done_i, .disp_mode_o, .disp_point_o);

/* File: src/rsar_core.v */
// Purpose: ratio selection, power-fail retention and watchdog of one
//   processing_display_module
// Assumes: all inputs synchronous to clk_sys_i; nvm_done_i pulses once
//   per word access
// Notes: one instance per phase module
`timescale 1ns/1ps
`include "rsar_map.vh"

module rsar_core
#(
  parameter [24:0] WDT_CYC = `RSAR_WDT_MS * `RSAR_CYC_PER_MS,
  parameter [24:0] CHECK_CYC = `RSAR_CHECK_MS * `RSAR_CYC_PER_MS,
  parameter [24:0] CONFIRM_CYC = `RSAR_CONFIRM_MS * `RSAR_CYC_PER_MS,
  parameter [24:0] DEBOUNCE_CYC = `RSAR_DEBOUNCE_MS * `RSAR_CYC_PER_MS
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // supply and controller
  input wire power_good_i,
  input wire wdt_kick_i,
  output reg wdt_recover_o,
  // front panel
  input wire [1:0] toggle_i,
  input wire button_i,
  input wire decimal_point_jumper_i,
  input wire voltage_transformer_i,
  // measurement
  input wire [14:0] rms_i,
  input wire [15:0] meas_data_i,
  output reg [15:0] meas_data_o,
  output reg resumed_o,
  output reg demand_reset_o,
  // nonvolatile memory
  output reg nvm_req_o,
  output reg nvm_we_o,
  output reg [1:0] nvm_addr_o,
  output reg [15:0] nvm_wdata_o,
  input wire [15:0] nvm_rdata_i,
  input wire nvm_done_i,
  // displays
  output reg [1:0] disp_mode_o,
  output reg [13:0] disp_ratio_o,
  output reg [14:0] disp_value_o,
  output reg disp_point_o
);

// =====================================================================
// states
localparam [3:0] ST_RESTORE = 4'b0001;
localparam [3:0] ST_RUN = 4'b0010;
localparam [3:0] ST_SAVE = 4'b0100;
localparam [3:0] ST_HOLD = 4'b1000;

reg [3:0] state_q;
reg step_q;
reg [4:0] active_q;
reg [4:0] sel_q;
reg in_ratio_q;
reg [24:0] timer_q;
reg [24:0] wdt_q;
reg [15:0] snap_q;
wire press;
wire [4:0] last_idx;
wire [4:0] sel_next;
wire [28:0] product;
wire [28:0] scaled;

// =====================================================================
// ratio table, decades ignored
function [13:0] ratio_val;
  input pt;
  input [4:0] idx;
  begin
    ratio_val = 14'h0;
    if (!pt)
      case (idx)
        5'h00: ratio_val = 14'd500;
        5'h01: ratio_val = 14'd600;
        5'h02: ratio_val = 14'd750;
        5'h03: ratio_val = 14'd800;
        5'h04: ratio_val = 14'd900;
        5'h05: ratio_val = 14'd1000;
        5'h06: ratio_val = 14'd1100;
        5'h07: ratio_val = 14'd1200;
        5'h08: ratio_val = 14'd1500;
        5'h09: ratio_val = 14'd1600;
        5'h0a: ratio_val = 14'd2000;
        5'h0b: ratio_val = 14'd2200;
        5'h0c: ratio_val = 14'd2400;
        5'h0d: ratio_val = 14'd2500;
        5'h0e: ratio_val = 14'd3000;
        5'h0f: ratio_val = 14'd3500;
        5'h10: ratio_val = 14'd4000;
        5'h11: ratio_val = 14'd4500;
        5'h12: ratio_val = 14'd5000;
        5'h13: ratio_val = 14'd6000;
        5'h14: ratio_val = 14'd7500;
        5'h15: ratio_val = 14'd8000;
        5'h16: ratio_val = 14'd9000;
        default: ratio_val = 14'd500;
      endcase
    else
      case (idx)
        5'h00: ratio_val = 14'd100;
        5'h01: ratio_val = 14'd110;
        5'h02: ratio_val = 14'd115;
        5'h03: ratio_val = 14'd120;
        5'h04: ratio_val = 14'd137;
        5'h05: ratio_val = 14'd140;
        5'h06: ratio_val = 14'd150;
        5'h07: ratio_val = 14'd173;
        5'h08: ratio_val = 14'd175;
        5'h09: ratio_val = 14'd180;
        5'h0a: ratio_val = 14'd200;
        5'h0b: ratio_val = 14'd231;
        5'h0c: ratio_val = 14'd240;
        5'h0d: ratio_val = 14'd250;
        5'h0e: ratio_val = 14'd251;
        5'h0f: ratio_val = 14'd300;
        5'h10: ratio_val = 14'd346;
        5'h11: ratio_val = 14'd350;
        5'h12: ratio_val = 14'd375;
        5'h13: ratio_val = 14'd400;
        5'h14: ratio_val = 14'd435;
        5'h15: ratio_val = 14'd450;
        5'h16: ratio_val = 14'd500;
        5'h17: ratio_val = 14'd577;
        5'h18: ratio_val = 14'd600;
        5'h19: ratio_val = 14'd625;
        5'h1a: ratio_val = 14'd635;
        5'h1b: ratio_val = 14'd664;
        5'h1c: ratio_val = 14'd693;
        5'h1d: ratio_val = 14'd700;
        5'h1e: ratio_val = 14'd800;
        default: ratio_val = 14'd808;
      endcase
  end
endfunction

rsar_press #(
  .STABLE_CYC(DEBOUNCE_CYC)
) u_press (
  .clk_sys_i(clk_sys_i),
  .reset_i(reset_i),
  .raw_i(button_i),
  .press_o(press)
);

assign last_idx = voltage_transformer_i ? `RSAR_PT_LAST : `RSAR_CT_LAST;
assign sel_next = (sel_q >= last_idx) ? `RSAR_IDX_FIRST : sel_q + 5'd1;
// full scale input maps to the ratio's primary value
assign product = rms_i * ratio_val(voltage_transformer_i, active_q);
assign scaled = product / `RSAR_FULL_SCALE;

// =====================================================================
// display values and jumper
always @(posedge clk_sys_i)
begin
  if (reset_i)
  begin
    disp_value_o <= 15'h0;
    disp_point_o <= 1'b0;
    disp_ratio_o <= 14'h0;
  end
  else
  begin
    disp_value_o <= scaled[14:0];
    disp_point_o <= decimal_point_jumper_i;
    if (disp_mode_o == `RSAR_DISP_RATIO)
      disp_ratio_o <= ratio_val(voltage_transformer_i, sel_q);
    else
      disp_ratio_o <= ratio_val(voltage_transformer_i, active_q);
  end
end

// =====================================================================
// watchdog
always @(posedge clk_sys_i)
begin
  if (reset_i)
  begin
    wdt_q <= 25'h0;
    wdt_recover_o <= 1'b0;
  end
  else
  begin
    wdt_recover_o <= 1'b0;
    if (wdt_kick_i)
      wdt_q <= 25'h0;
    else if (wdt_q >= WDT_CYC - 25'd1)
    begin
      wdt_q <= 25'h0;
      wdt_recover_o <= 1'b1;
    end
    else
      wdt_q <= wdt_q + 25'd1;
  end
end

// =====================================================================
// retention sequencing and ratio selection
always @(posedge clk_sys_i)
begin
  if (reset_i)
  begin
    state_q <= ST_RESTORE;
    step_q <= `RSAR_NVM_STEP_FIRST;
    active_q <= `RSAR_IDX_RESET;
    sel_q <= `RSAR_IDX_RESET;
    in_ratio_q <= 1'b0;
    timer_q <= 25'h0;
    snap_q <= 16'h0;
    meas_data_o <= 16'h0;
    resumed_o <= 1'b0;
    demand_reset_o <= 1'b0;
    nvm_req_o <= 1'b0;
    nvm_we_o <= 1'b0;
    nvm_addr_o <= `RSAR_NVM_ADDR_RATIO;
    nvm_wdata_o <= 16'h0;
    disp_mode_o <= `RSAR_DISP_NORMAL;
  end
  else
  begin
    resumed_o <= 1'b0;
    demand_reset_o <= 1'b0;
    case (state_q)
      ST_RESTORE:
      begin
        // no reads until the supply is good again
        nvm_we_o <= 1'b0;
        nvm_addr_o <= step_q ? `RSAR_NVM_ADDR_DATA : `RSAR_NVM_ADDR_RATIO;
        nvm_req_o <= power_good_i & ~nvm_done_i;
        if (nvm_req_o && nvm_done_i)
        begin
          if (step_q == `RSAR_NVM_STEP_FIRST)
          begin
            // a bad stored index falls back to the first entry
            if (nvm_rdata_i[4:0] > last_idx)
              active_q <= `RSAR_IDX_FIRST;
            else
              active_q <= nvm_rdata_i[4:0];
            step_q <= `RSAR_NVM_STEP_LAST;
          end
          else
          begin
            meas_data_o <= nvm_rdata_i;
            resumed_o <= 1'b1;
            step_q <= `RSAR_NVM_STEP_FIRST;
            state_q <= ST_RUN;
          end
        end
      end
      ST_RUN:
      begin
        if (!power_good_i)
        begin
          snap_q <= meas_data_i;
          in_ratio_q <= 1'b0;
          disp_mode_o <= `RSAR_DISP_NORMAL;
          state_q <= ST_SAVE;
        end
        else if (toggle_i == `RSAR_TOG_RATIO)
        begin
          disp_mode_o <= `RSAR_DISP_RATIO;
          if (!in_ratio_q)
          begin
            in_ratio_q <= 1'b1;
            sel_q <= active_q;
          end
          else if (press)
            sel_q <= sel_next;
        end
        else if (in_ratio_q)
        begin
          if (toggle_i == `RSAR_TOG_CENTER)
          begin
            in_ratio_q <= 1'b0;
            disp_mode_o <= `RSAR_DISP_CHECK;
            timer_q <= CHECK_CYC - 25'd1;
          end
        end
        else if (disp_mode_o == `RSAR_DISP_CHECK)
        begin
          if (timer_q == 25'h0)
          begin
            active_q <= sel_q;
            disp_mode_o <= `RSAR_DISP_NORMAL;
          end
          else
            timer_q <= timer_q - 25'd1;
        end
        else if (press)
        begin
          demand_reset_o <= 1'b1;
          disp_mode_o <= `RSAR_DISP_CONFIRM;
          timer_q <= CONFIRM_CYC - 25'd1;
        end
        else if (disp_mode_o == `RSAR_DISP_CONFIRM)
        begin
          if (timer_q == 25'h0)
            disp_mode_o <= `RSAR_DISP_NORMAL;
          else
            timer_q <= timer_q - 25'd1;
        end
        else
          disp_mode_o <= `RSAR_DISP_NORMAL;
      end
      ST_SAVE:
      begin
        nvm_we_o <= 1'b1;
        nvm_addr_o <= step_q ? `RSAR_NVM_ADDR_DATA : `RSAR_NVM_ADDR_RATIO;
        nvm_wdata_o <= step_q ? snap_q : {11'h0, active_q};
        nvm_req_o <= ~nvm_done_i;
        if (nvm_req_o && nvm_done_i)
        begin
          if (step_q == `RSAR_NVM_STEP_LAST)
          begin
            step_q <= `RSAR_NVM_STEP_FIRST;
            state_q <= ST_HOLD;
          end
          else
            step_q <= `RSAR_NVM_STEP_LAST;
        end
      end
      ST_HOLD:
      begin
        // brownout that recovers without a reset reloads as at power-up
        nvm_req_o <= 1'b0;
        nvm_we_o <= 1'b0;
        if (power_good_i)
          state_q <= ST_RESTORE;
      end
      default:
        state_q <= ST_RESTORE;
    endcase
  end
end

endmodule

/* File: src/rsar_map.vh */
// Purpose: constants for the ratio select and retention block
// Assumes: 20 MHz system clock
// Notes: included by the design files of this block
`ifndef RSAR_MAP_VH
`define RSAR_MAP_VH

// =====================================================================
// timing
`define RSAR_CLK_HZ 20000000
`define RSAR_CYC_PER_MS (`RSAR_CLK_HZ / 1000)
`define RSAR_WDT_MS 100
`define RSAR_CHECK_MS 1000
`define RSAR_CONFIRM_MS 1000
`define RSAR_DEBOUNCE_MS 10

// =====================================================================
// nonvolatile memory word layout
`define RSAR_NVM_ADDR_RATIO 2'h0
`define RSAR_NVM_ADDR_DATA 2'h1
`define RSAR_NVM_STEP_FIRST 1'b0
`define RSAR_NVM_STEP_LAST 1'b1

// =====================================================================
// ratio tables, toggle and display codes
`define RSAR_CT_LAST 5'h16
`define RSAR_PT_LAST 5'h1f
`define RSAR_IDX_FIRST 5'h00
`define RSAR_IDX_RESET 5'h00
`define RSAR_FULL_SCALE 15'h2710
`define RSAR_TOG_CENTER 2'h0
`define RSAR_TOG_RATIO 2'h1
`define RSAR_DISP_NORMAL 2'h0
`define RSAR_DISP_RATIO 2'h1
`define RSAR_DISP_CHECK 2'h2
`define RSAR_DISP_CONFIRM 2'h3

`endif

/* File: src/rsar_press.v */
// Purpose: debounce a push-button and flag each new press
// Assumes: input synchronous to clk_sys_i, active high when pressed
// Notes: press_o is a one-cycle pulse after a stable closure
`timescale 1ns/1ps
`include "rsar_map.vh"

module rsar_press
#(
  parameter [24:0] STABLE_CYC = 25'd200000
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // button
  input wire raw_i,
  output reg press_o
);

reg level_q;
reg [24:0] cnt_q;

always @(posedge clk_sys_i)
begin
  if (reset_i)
  begin
    level_q <= 1'b0;
    cnt_q <= 25'h0;
    press_o <= 1'b0;
  end
  else
  begin
    press_o <= 1'b0;
    if (raw_i == level_q)
      cnt_q <= 25'h0;
    else if (cnt_q >= STABLE_CYC - 25'd1)
    begin
      // contact bounce shorter than the window never changes the level
      level_q <= raw_i;
      cnt_q <= 25'h0;
      press_o <= raw_i;
    end
    else
      cnt_q <= cnt_q + 25'd1;
  end
end

endmodule
